// File: smrf_top.sv
// command decoder and mode register three/four feature logic
`timescale 1ns/100ps
module smrf_top #(
   parameter int TEMP_CYCLES = smrf_pkg::TEMP_CYC
) (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        cs_n,
   input  wire logic        act_n,
   input  wire logic        ras_n,
   input  wire logic        cas_n,
   input  wire logic        we_n,
   input  wire logic [21:0] mrs_addr,
   input  wire logic        pda_select,
   input  wire logic        sync_pulse,
   input  wire logic [1:0]  temp_status,
   output logic [21:0]      feature_mode_reg_four,
   output logic [21:0]      mode_reg_three,
   output logic             multi_purpose_pattern_reg,
   output logic [1:0]       pattern_read_format,
   output logic [1:0]       pattern_page,
   output logic [1:0]       crc_mask_write_cmd_latency,
   output logic             quarter_rate_clocking,
   output logic             rd_data_valid,
   output logic [7:0]       rd_data,
   output logic             hard_row_repair,
   output logic             soft_row_repair,
   output logic             write_preamble_2ck,
   output logic             read_preamble_2ck,
   output logic             preamble_training,
   output logic             self_refresh_abort,
   output logic [3:0]       cmd_addr_latency,
   output logic             vref_monitor,
   output logic             temp_ctrl_refresh,
   output logic             temp_range_ext,
   output logic             max_power_save,
   output logic             dnu_seen
);
   // ***********************************************
   // state
   // ***********************************************
   typedef struct packed {
      logic [21:0]           mr3;
      logic [21:0]           mr4;
      smrf_pkg::smrf_mode_type mode;
      logic                  gear_pend;
      logic                  quarter;
      logic [1:0]            temp;
      logic [23:0]           tcnt;
      logic                  rvalid;
      logic [7:0]            rdata;
      logic                  do_not_use_code;
      logic [3:0]            cal;
   } smrf_state_type;

   smrf_state_type st_r;
   smrf_state_type st_nxt;
   logic           mrs_cmd;
   logic           rd_cmd;
   logic           act_ok;
   logic [2:0]     sel;
   logic [21:0]    rd_reg;

   // ***********************************************
   // command decode
   // ***********************************************
   // mrs decode
   assign mrs_cmd = !cs_n && act_n && !ras_n && !cas_n && !we_n;
   assign rd_cmd  = !cs_n && act_n && ras_n && !cas_n && we_n;
   assign act_ok  = !st_r.mr3[smrf_pkg::MR3_PDA] || pda_select;
   assign sel     = mrs_addr[smrf_pkg::SEL_HI:smrf_pkg::SEL_LO];

   // register picked by read address bits 2:0
   always_comb
   begin
      rd_reg = 22'h000000;
      unique case (mrs_addr[2:0])
         smrf_pkg::SEL_MR3: rd_reg = st_r.mr3;
         smrf_pkg::SEL_MR4: rd_reg = st_r.mr4;
         default:           rd_reg = 22'h000000;
      endcase
   end

   // ***********************************************
   // next state
   // ***********************************************
   always_comb
   begin
      st_nxt        = st_r;
      st_nxt.rvalid = 1'b0;
      st_nxt.do_not_use_code    = 1'b0;
      if (st_r.tcnt >= 24'(TEMP_CYCLES - 1))
      begin
         st_nxt.tcnt = 24'h000000;
         if (st_r.mr3[smrf_pkg::MR3_TSS])
            st_nxt.temp = temp_status;
      end
      else
         st_nxt.tcnt = st_r.tcnt + 24'h000001;
      if (mrs_cmd && act_ok)
      begin
         if (sel == smrf_pkg::SEL_DNU)
            st_nxt.do_not_use_code = 1'b1;
         else if (sel == smrf_pkg::SEL_MR4)
            st_nxt.mr4 = mrs_addr & ~smrf_pkg::MR4_RSVD_MASK;
         else if (sel == smrf_pkg::SEL_MR3)
         begin
            st_nxt.mr3 = mrs_addr;
            st_nxt.mode = mrs_addr[smrf_pkg::MR3_MPR] ?
                          smrf_pkg::SMRF_PATTERN : smrf_pkg::SMRF_NORMAL;
            // gear-down arm, half rate on clear
            st_nxt.gear_pend = mrs_addr[smrf_pkg::MR3_GEAR];
            if (!mrs_addr[smrf_pkg::MR3_GEAR])
               st_nxt.quarter = 1'b0;
         end
      end
      if (st_r.gear_pend && sync_pulse)
      begin
         st_nxt.quarter   = 1'b1;
         st_nxt.gear_pend = 1'b0;
      end
      if (rd_cmd && act_ok && st_r.mode == smrf_pkg::SMRF_PATTERN)
      begin
         st_nxt.rvalid = 1'b1;
         if (mrs_addr[3])
            st_nxt.rdata = {2'h0, rd_reg[21:16]};
         else if (mrs_addr[4])
            st_nxt.rdata = rd_reg[15:8];
         else
            st_nxt.rdata = rd_reg[7:0];
         // temperature bits on page 2 location 0
         if (st_r.mr3[1:0] == smrf_pkg::PAGE_TEMP[1:0] &&
             mrs_addr[1:0] == 2'h0)
            st_nxt.rdata = {3'h0, st_r.temp, 3'h0};
      end
      // latency clocks, registered together with the field
      unique case (st_nxt.mr4[smrf_pkg::MR4_CAL_HI:smrf_pkg::MR4_CAL_LO])
         3'h1:    st_nxt.cal = 4'h3;
         3'h2:    st_nxt.cal = 4'h4;
         3'h3:    st_nxt.cal = 4'h5;
         3'h4:    st_nxt.cal = 4'h6;
         3'h6:    st_nxt.cal = 4'h8;
         default: st_nxt.cal = 4'h0;
      endcase
   end

   // reset clears everything including pattern mode
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         st_r           <= '0;
         st_r.mr3       <= smrf_pkg::MR3_RESET;
         st_r.mr4       <= smrf_pkg::MR4_RESET;
         st_r.mode      <= smrf_pkg::SMRF_NORMAL;
      end
      else
         st_r <= st_nxt;
   end

   // ***********************************************
   // outputs straight from state
   // ***********************************************
   assign feature_mode_reg_four = st_r.mr4;
   assign mode_reg_three        = st_r.mr3;
   assign multi_purpose_pattern_reg = st_r.mode == smrf_pkg::SMRF_PATTERN;
   assign pattern_read_format   = st_r.mr3[12:11];
   assign pattern_page          = st_r.mr3[1:0];
   assign crc_mask_write_cmd_latency = st_r.mr3[10:9];
   assign quarter_rate_clocking = st_r.quarter;
   assign rd_data_valid         = st_r.rvalid;
   assign rd_data               = st_r.rdata;
   assign hard_row_repair       = st_r.mr4[smrf_pkg::MR4_HARD_ROW_REPAIR];
   assign soft_row_repair       = st_r.mr4[smrf_pkg::MR4_SOFT_ROW_REPAIR];
   assign write_preamble_2ck    = st_r.mr4[smrf_pkg::MR4_WPRE];
   assign read_preamble_2ck     = st_r.mr4[smrf_pkg::MR4_RPRE];
   assign preamble_training     = st_r.mr4[smrf_pkg::MR4_RPT];
   assign self_refresh_abort    = st_r.mr4[smrf_pkg::MR4_SRA];
   assign vref_monitor          = st_r.mr4[smrf_pkg::MR4_VREFMON];
   assign temp_ctrl_refresh     = st_r.mr4[smrf_pkg::MR4_TCR];
   assign temp_range_ext        = st_r.mr4[smrf_pkg::MR4_TCR_EXT];
   assign max_power_save        = st_r.mr4[smrf_pkg::MR4_MPS];
   assign dnu_seen              = st_r.do_not_use_code;

   assign cmd_addr_latency      = st_r.cal;
endmodule

// File: smrf_pkg.sv
// shared constants and types for the mode register three/four feature block
package smrf_pkg;
   // ***********************************************
   // mode register set field layout
   // ***********************************************
   localparam int          MRS_W         = 22;
   localparam int          SEL_HI        = 20;
   localparam int          SEL_LO        = 18;
   localparam logic [2:0]  SEL_MR3       = 3'h3;
   localparam logic [2:0]  SEL_MR4       = 3'h4;
   localparam logic [2:0]  SEL_DNU       = 3'h7;
   // third register fields
   localparam int          MR3_FMT_HI    = 12;
   localparam int          MR3_FMT_LO    = 11;
   localparam int          MR3_WCL_HI    = 10;
   localparam int          MR3_WCL_LO    = 9;
   localparam int          MR3_TSS       = 5;
   localparam int          MR3_PDA       = 4;
   localparam int          MR3_GEAR      = 3;
   localparam int          MR3_MPR       = 2;
   localparam int          MR3_PAGE_HI   = 1;
   localparam int          MR3_PAGE_LO   = 0;
   // fourth register fields
   localparam int          MR4_HARD_ROW_REPAIR      = 13;
   localparam int          MR4_WPRE      = 12;
   localparam int          MR4_RPRE      = 11;
   localparam int          MR4_RPT       = 10;
   localparam int          MR4_SRA       = 9;
   localparam int          MR4_CAL_HI    = 8;
   localparam int          MR4_CAL_LO    = 6;
   localparam int          MR4_SOFT_ROW_REPAIR      = 5;
   localparam int          MR4_VREFMON   = 4;
   localparam int          MR4_TCR       = 3;
   localparam int          MR4_TCR_EXT   = 2;
   localparam int          MR4_MPS       = 1;
   localparam logic [21:0] MR4_RSVD_MASK = 22'h220001;
   localparam logic [21:0] MR4_RESET     = 22'h000000;
   localparam logic [21:0] MR3_RESET     = 22'h000000;
   // ***********************************************
   // timing
   // ***********************************************
   localparam int          CLK_HZ        = 20_000_000;
   localparam int          TEMP_MS       = 32;
   localparam int          TEMP_CYC      = TEMP_MS * (CLK_HZ / 1000);
   localparam int          CNT_W         = 24;
   localparam logic [2:0]  PAGE_TEMP     = 3'h2;
   // readout state
   typedef enum logic [0:0] {SMRF_NORMAL, SMRF_PATTERN} smrf_mode_type;
endpackage

// File: smrf_ctrl_model.sv
// controller model that drives mode register set and read commands
`timescale 1ns/100ps
module smrf_ctrl_model (
   input  wire logic  clk_sys,
   output logic       cs_n,
   output logic       act_n,
   output logic       ras_n,
   output logic       cas_n,
   output logic       we_n,
   output logic [21:0] mrs_addr
);
   // no activates issued, so all banks stay idle
   // idle: deselected, address parked
   initial
   begin
      {cs_n, act_n, ras_n, cas_n, we_n} = 5'h1f;
      mrs_addr = 22'h0;
   end
   // one command cycle, then deselect and scramble the stale address
   task automatic issue(input logic [2:0] rcw, input logic [21:0] a);
      @(posedge clk_sys);
      {cs_n, ras_n, cas_n, we_n} <= {1'b0, rcw};
      mrs_addr <= a;
      @(posedge clk_sys);
      {cs_n, ras_n, cas_n, we_n} <= 4'hf;
      mrs_addr <= ~a;
   endtask
   task automatic mrs(input logic [21:0] a);
      issue(3'h0, a);
   endtask
   // read command, issued in any mode
   task automatic rd(input logic [21:0] a);
      issue(3'h5, a);
   endtask
endmodule

// File: smrf_chk_sva.sv
// assertion checker for the mode register three/four feature block
`timescale 1ns/100ps
module smrf_chk (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        cs_n,
   input wire logic        act_n,
   input wire logic        ras_n,
   input wire logic        cas_n,
   input wire logic        we_n,
   input wire logic [21:0] mrs_addr,
   input wire logic        pda_select,
   input wire logic [21:0] feature_mode_reg_four,
   input wire logic [21:0] mode_reg_three,
   input wire logic        multi_purpose_pattern_reg,
   input wire logic        rd_data_valid,
   input wire logic [3:0]  cmd_addr_latency,
   input wire logic        dnu_seen,
   input wire logic        hard_row_repair,
   input wire logic        write_preamble_2ck
);
   logic       ok_c;
   logic       mrs_c;
   logic       rd_c;
   logic [2:0] sel;
   logic [2:0] cal;
   // decoded commands that this device takes
   assign ok_c = !cs_n && act_n && (!mode_reg_three[4] || pda_select);
   assign mrs_c = ok_c && !ras_n && !cas_n && !we_n;
   assign rd_c = ok_c && ras_n && !cas_n && we_n;
   assign sel = mrs_addr[20:18];
   assign cal = feature_mode_reg_four[8:6];
   default clocking dc @(posedge clk_sys); endclocking
   default disable iff (rst);
   chk_mr4_latch: assert property (mrs_c && sel == 3'h4
      |=> feature_mode_reg_four == ($past(mrs_addr) & ~22'h220001))
      else $error("mr4 value not latched");
   chk_mr4_hold: assert property (!(mrs_c && sel == 3'h4)
      |=> $stable(feature_mode_reg_four)) else $error("mr4 changed");
   chk_dnu_pulse: assert property (mrs_c && sel == 3'h7
      |=> dnu_seen && $stable(feature_mode_reg_four))
      else $error("unused select not refused");
   chk_pattern_entry: assert property (mrs_c && sel == 3'h3
      |=> multi_purpose_pattern_reg == $past(mrs_addr[2]))
      else $error("pattern mode entry wrong");
   chk_read_pulse: assert property (rd_c
      |=> rd_data_valid == $past(multi_purpose_pattern_reg))
      else $error("read pulse wrong");
   chk_valid_cause: assert property (rd_data_valid |-> $past(rd_c))
      else $error("stray read pulse");
   chk_cal_decode: assert property (
      cmd_addr_latency == 4'(cal == 3'h6 ? 8 : (cal inside {[1:4]}) ? cal + 2 : 0))
      else $error("latency decode wrong");
   chk_preamble_len: assert property (mrs_c && sel == 3'h4
      |=> write_preamble_2ck == $past(mrs_addr[12])
      && hard_row_repair == $past(mrs_addr[13])) else $error("mr4 bits");
   chk_pda_mask: assert property (mode_reg_three[4] && !pda_select
      |=> $stable(feature_mode_reg_four) && !rd_data_valid)
      else $error("unaddressed command acted on");
endmodule
bind smrf_top smrf_chk u_smrf_chk (.clk_sys, .rst, .cs_n, .act_n, .ras_n,
   .cas_n, .we_n, .mrs_addr, .pda_select, .feature_mode_reg_four,
   .mode_reg_three, .multi_purpose_pattern_reg, .rd_data_valid,
   .cmd_addr_latency, .dnu_seen, .hard_row_repair, .write_preamble_2ck);

// File: tb_smrf_top.sv
// testbench for the mode register three/four feature block
`timescale 1ns/100ps
module tb_smrf_top;
   logic clk_sys = 1'b0, rst = 1'b1, pda_select = 1'b1, sync_pulse = 1'b0;
   logic [1:0] temp_status = 2'h2, pattern_read_format, pattern_page;
   logic cs_n, act_n, ras_n, cas_n, we_n, rd_data_valid, dnu_seen;
   logic [21:0] mrs_addr, feature_mode_reg_four, mode_reg_three, v;
   logic [1:0] crc_mask_write_cmd_latency;
   logic [3:0] cmd_addr_latency;
   logic [7:0] rd_data;
   logic multi_purpose_pattern_reg, quarter_rate_clocking, hard_row_repair;
   logic soft_row_repair, write_preamble_2ck, read_preamble_2ck;
   logic preamble_training, self_refresh_abort, vref_monitor;
   logic temp_ctrl_refresh, temp_range_ext, max_power_save;
   int err_total = 0, total_checks = 0, cyc = 0;
   wire [9:0] flags = {hard_row_repair, soft_row_repair, write_preamble_2ck,
      read_preamble_2ck, preamble_training, self_refresh_abort,
      vref_monitor, temp_ctrl_refresh, temp_range_ext, max_power_save};
   always #25 clk_sys = ~clk_sys;
   smrf_top #(.TEMP_CYCLES(16)) u_smrf_top (.clk_sys, .rst, .cs_n, .act_n,
      .ras_n, .cas_n, .we_n, .mrs_addr, .pda_select, .sync_pulse,
      .temp_status, .feature_mode_reg_four, .mode_reg_three,
      .multi_purpose_pattern_reg, .pattern_read_format, .pattern_page,
      .crc_mask_write_cmd_latency, .quarter_rate_clocking, .rd_data_valid,
      .rd_data, .hard_row_repair, .soft_row_repair, .write_preamble_2ck,
      .read_preamble_2ck, .preamble_training, .self_refresh_abort,
      .cmd_addr_latency, .vref_monitor, .temp_ctrl_refresh, .temp_range_ext,
      .max_power_save, .dnu_seen);
   smrf_ctrl_model u_smrf_ctrl_model (.clk_sys, .cs_n, .act_n, .ras_n,
      .cas_n, .we_n, .mrs_addr);
   // compare and count
   task automatic chk(string n, logic [22:0] seen, logic [22:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic mr(logic [21:0] a);
      u_smrf_ctrl_model.mrs(a);
      #1;
   endtask
   task automatic rd(logic [21:0] a, logic [7:0] e);
      u_smrf_ctrl_model.rd(a);
      #1;
      chk("rd_valid", rd_data_valid, 1'b1);
      chk("rd_data", rd_data, e);
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // hang guard
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         err_total++;
         print_verdict;
      end
   end
   // main sequence
   initial
   begin
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      #1;
      chk("mr4_reset", feature_mode_reg_four, 0);
      u_smrf_ctrl_model.rd(22'h4);
      #1;
      chk("rd_idle", rd_data_valid, 0);
      // write cas latency lives outside this block
      for (int i = 0; i < 15; i++)
      begin
         v = (i == 14) ? 22'h320001 : 22'h100000 | (22'h1 << i);
         mr(v);
         chk("flags", flags, {v[13], v[5], v[12:9], v[4:1]});
         chk("rsvd", feature_mode_reg_four & 22'h220001, 0);
      end
      for (int c = 0; c < 8; c++)
      begin
         mr(22'h100000 | 22'(c << 6));
         chk("cal", cmd_addr_latency, c == 6 ? 8 : c inside {[1:4]} ? c + 2 : 0);
      end
      mr(22'h1c2000);
      chk("dnu", {dnu_seen, feature_mode_reg_four}, 23'h5001c0);
      $display("test fields done");
      mr(22'h102a5a);
      mr(22'h0c1004);
      chk("mode", {multi_purpose_pattern_reg, pattern_read_format}, 3'h6);
      rd(22'h4, 8'h5a);
      rd(22'h14, 8'h2a);
      rd(22'hc, 8'h10);
      mr(22'h0c1026);
      chk("mr3", mode_reg_three, 22'h0c1026);
      chk("page", pattern_page, 2'h2);
      @(posedge clk_sys) temp_status <= 2'h1;
      repeat (40) @(posedge clk_sys);
      rd(22'h0, 8'h08);
      $display("test pattern done");
      // six-clock crc/mask latency for the top rate band
      mr(22'h0c0418);
      chk("gear", {quarter_rate_clocking, crc_mask_write_cmd_latency}, 3'h2);
      @(posedge clk_sys) sync_pulse <= 1'b1;
      @(posedge clk_sys) sync_pulse <= 1'b0;
      #1;
      chk("quarter", quarter_rate_clocking, 1'b1);
      // two-clock preamble write ignored unless pda_select is high
      @(posedge clk_sys) pda_select <= 1'b0;
      mr(22'h101802);
      chk("pda_off", feature_mode_reg_four, 22'h102a5a);
      @(posedge clk_sys) pda_select <= 1'b1;
      mr(22'h101802);
      chk("pda_on", feature_mode_reg_four, 22'h101802);
      mr(22'h0c0004);
      @(posedge clk_sys) rst <= 1'b1;
      @(posedge clk_sys);
      @(posedge clk_sys) rst <= 1'b0;
      #1;
      chk("rst", {multi_purpose_pattern_reg, feature_mode_reg_four}, 0);
      $display("test modes done");
      print_verdict;
   end
endmodule
